// >>> design/media_stream_packetizer.sv
// Purpose: Packs samples into timestamped packets and places received packets
//          into a per-channel playout buffer on the local media clock
// Assumes: media_tick_in is a one-cycle enable per local media sample period
// Notes:   One sample per packet word; byte packing is left to the network side
//
// Chosen here: the register addresses and the plain strobed port.
`include "media_stream_packetizer_params.svh"
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Multicast destinations always accepted; unicast accepted when enabled
// - Carries 16-bit and 24-bit linear audio payloads
// - Receives any channel count from one up to eight
// - Offers a transparent 32-bit payload format
// - Packet and octet counts kept for control reports
// - Transmit packets never exceed the network payload limit
// - Receiver accepts any samples per packet, varying freely
// - Per-packet sample count taken from software at packet start; packet ends early when the next frame would pass the payload limit
// - Packets leave immediately after samples, no extra buffering
// - Receive buffer holds 1024 samples per channel
// - Timestamp is media count of first sample plus stream offset
// - Received timestamps mapped to local clock plus playout latency
// - Stream description compared to local settings; mismatches refused
// - Missing sync source attribute means unknown source, refused unless allowed
// - Only a time-reference domain with its number is a valid source
// - Epoch timestamp is a 32-bit unsigned value with wrap-around
// - Epoch timestamp ignored when no sync source attribute exists
// - Missing epoch timestamp refuses the stream unless guessing is allowed
// - Absent rate ratio means one to one
// - Actual rate compared exactly by cross multiplication
// - Rate ratio always parsed; mismatching rate refuses the stream
// - Stream mapping fixed at start, never realigned while running
// - Epoch count register gives media count at the reference epoch
// - Media count advances only on the locked media clock enable
module media_stream_packetizer (
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  // Register port
  input  wire logic [`MSP_AW-1:0]  reg_addr_in,
  input  wire logic [`MSP_DW-1:0]  reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [`MSP_DW-1:0]  reg_rdata_out,
  // Local media clock
  input  wire logic                media_tick_in,
  // Transmit samples in
  input  wire logic [31:0]         tx_smp_data_in,
  input  wire logic                tx_smp_valid_in,
  output logic                     tx_smp_ready_out,
  // Transmit packet words out
  output msp_pkg::pkt_word_t       tx_pkt_out,
  output logic                     tx_pkt_valid_out,
  input  wire logic                tx_pkt_ready_in,
  // Receive packet words in
  input  wire msp_pkg::pkt_word_t  rx_pkt_in,
  input  wire logic                rx_pkt_valid_in,
  output logic                     rx_pkt_ready_out,
  // Playout
  output msp_pkg::sample_t         play_smp_out,
  output logic                     play_valid_out,
  output logic                     rx_running_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] ri(input logic [7:0] a);
    return a[5:2];
  endfunction

  function automatic logic [2:0] fmt_bytes(input msp_pkg::fmt_t f);
    unique case (f)
      msp_pkg::FMT_L16: fmt_bytes = `L16_BYTES;
      msp_pkg::FMT_L24: fmt_bytes = `L24_BYTES;
      default:          fmt_bytes = `W32_BYTES;
    endcase
  endfunction

  // Samples arrive left-justified; payload words carry them right-justified
  function automatic logic [31:0] pack(input msp_pkg::fmt_t f, input logic [31:0] d);
    unique case (f)
      msp_pkg::FMT_L16: pack = {16'h0000, d[31:16]};
      msp_pkg::FMT_L24: pack = {8'h00, d[31:8]};
      default:          pack = d;
    endcase
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] cfg [0:15];
  logic [31:0] mclk;
  logic [31:0] tx_pkts;
  logic [31:0] tx_octets;
  logic [31:0] rx_pkts;
  logic [31:0] status;

  wire       cfg_sel = (reg_addr_in[7:6] == 2'b00) && (reg_addr_in[1:0] == 2'b00);
  wire [3:0] acc_idx = reg_addr_in[5:2];
  wire       mclk_wr = reg_wr_in && (reg_addr_in == `REG_MCLK);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) begin
        cfg[i] <= 32'h0000_0000;
      end
      cfg[ri(`REG_TX_CFG)]     <= `TX_CFG_RST;
      cfg[ri(`REG_LOCAL_RATE)] <= `LOCAL_RATE_RST;
    end else if (reg_wr_in && cfg_sel) begin
      cfg[acc_idx] <= reg_wdata_in;
    end
  end

  wire [31:0] ctrl        = cfg[ri(`REG_CTRL)];
  wire [31:0] tx_cfg      = cfg[ri(`REG_TX_CFG)];
  wire [31:0] tx_offset   = cfg[ri(`REG_TX_OFFSET)];
  wire [31:0] local_addr  = cfg[ri(`REG_LOCAL_ADDR)];
  wire [31:0] local_ports = cfg[ri(`REG_LOCAL_PORTS)];
  wire [31:0] local_cfg   = cfg[ri(`REG_LOCAL_CFG)];
  wire [19:0] local_rate  = cfg[ri(`REG_LOCAL_RATE)][19:0];
  wire [31:0] mclk_epoch  = cfg[ri(`REG_MCLK_EPOCH)];
  wire [31:0] latency     = cfg[ri(`REG_LATENCY)];
  wire [31:0] rx_addr     = cfg[ri(`REG_RX_ADDR)];
  wire [31:0] rx_ports    = cfg[ri(`REG_RX_PORTS)];
  wire [31:0] rx_desc     = cfg[ri(`REG_RX_DESC)];
  wire [31:0] rx_sync     = cfg[ri(`REG_RX_SYNC)];
  wire [31:0] rx_dev      = cfg[ri(`REG_RX_DEV)];
  wire [19:0] rx_rate     = cfg[ri(`REG_RX_RATE)][19:0];

  wire [31:0] cfg_rd = (acc_idx == ri(`REG_MCLK)) ? mclk : cfg[acc_idx];
  wire [31:0] rd_mux = cfg_sel                     ? cfg_rd    :
                       (reg_addr_in == `REG_STATUS)    ? status    :
                       (reg_addr_in == `REG_TX_PKTS)   ? tx_pkts   :
                       (reg_addr_in == `REG_TX_OCTETS) ? tx_octets :
                       (reg_addr_in == `REG_RX_PKTS)   ? rx_pkts   : 32'h0000_0000;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Local media clock count
  // ----------------------------------------
  // Software writes load the count and win over a tick; between writes only the locked tick moves it
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mclk <= 32'h0000_0000;
    end else if (mclk_wr) begin
      mclk <= reg_wdata_in;
    end else if (media_tick_in) begin
      mclk <= mclk + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Transmit packetizer
  // ----------------------------------------
  msp_pkg::tx_state_t tx_state;
  msp_pkg::fmt_t      pkt_fmt;
  logic [15:0]        pkt_spp;
  logic [3:0]         pkt_ch;
  logic [15:0]        tx_frm;
  logic [3:0]         tx_chn;
  logic [16:0]        pkt_bytes;

  wire        tx_en       = ctrl[`CTRL_TX_EN];
  wire        can_load    = !tx_pkt_valid_out || tx_pkt_ready_in;
  wire        tx_start    = (tx_state == msp_pkg::TX_IDLE) && tx_en && tx_smp_valid_in && can_load;
  wire        tx_take     = tx_smp_valid_in && tx_smp_ready_out;
  wire [16:0] frame_bytes = 17'({13'h0000, pkt_ch} * {14'h0000, fmt_bytes(pkt_fmt)});
  wire [16:0] pay_max     = `MTU_BYTES - `HDR_BYTES;
  wire        frame_end   = (tx_chn == pkt_ch - 4'h1);
  wire        mtu_next    = (pkt_bytes + frame_bytes + frame_bytes) > pay_max;
  wire        spp_done    = (tx_frm == pkt_spp - 16'h0001);
  wire        tx_last     = frame_end && (spp_done || mtu_next);

  assign tx_smp_ready_out = (tx_state == msp_pkg::TX_DATA) && can_load;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_state <= msp_pkg::TX_IDLE;
    end else if (tx_start) begin
      tx_state <= msp_pkg::TX_DATA;
    end else if (tx_take && tx_last) begin
      tx_state <= msp_pkg::TX_IDLE;
    end
  end

  // Packet shape is frozen at packet start so software edits act on the next one
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pkt_spp <= 16'h0000;
      pkt_ch  <= 4'h1;
      pkt_fmt <= msp_pkg::FMT_L16;
    end else if (tx_start) begin
      pkt_spp <= tx_cfg[15:0];
      pkt_ch  <= (tx_cfg[19:16] == 4'h0 || tx_cfg[19:16] > `CH_MAX) ? 4'h1 : tx_cfg[19:16];
      pkt_fmt <= msp_pkg::fmt_t'(tx_cfg[21:20]);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_frm    <= 16'h0000;
      tx_chn    <= 4'h0;
      pkt_bytes <= 17'h00000;
    end else if (tx_start) begin
      tx_frm    <= 16'h0000;
      tx_chn    <= 4'h0;
      pkt_bytes <= 17'h00000;
    end else if (tx_take) begin
      tx_chn <= frame_end ? 4'h0 : tx_chn + 4'h1;
      if (frame_end) begin
        tx_frm    <= tx_frm + 16'h0001;
        pkt_bytes <= pkt_bytes + frame_bytes;
      end
    end
  end

  // Header word carries the stream timestamp of the first sample
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_pkt_out       <= '0;
      tx_pkt_valid_out <= 1'b0;
    end else if (can_load) begin
      tx_pkt_valid_out <= tx_start || tx_take;
      if (tx_start) begin
        tx_pkt_out <= '{data: mclk + tx_offset, first: 1'b1, last: 1'b0};
      end else if (tx_take) begin
        tx_pkt_out <= '{data: pack(pkt_fmt, tx_smp_data_in), first: 1'b0, last: tx_last};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_pkts   <= 32'h0000_0000;
      tx_octets <= 32'h0000_0000;
    end else if (tx_take && tx_last) begin
      tx_pkts   <= tx_pkts + 32'h0000_0001;
      tx_octets <= tx_octets + {15'h0000, pkt_bytes + frame_bytes};
    end
  end

  // ----------------------------------------
  // Stream description check
  // ----------------------------------------
  wire        is_mcast   = (rx_addr[31:28] == `MCAST_PREFIX);
  wire        addr_ok    = (rx_addr == local_addr) && (is_mcast || ctrl[`CTRL_UCAST_EN]);
  wire        ports_ok   = (rx_ports == local_ports);
  wire        fmt_ok     = (rx_desc[1:0] == local_cfg[1:0]) && (rx_desc[1:0] != 2'(msp_pkg::FMT_BAD));
  wire [3:0]  rx_ch      = rx_desc[5:2];
  wire        ch_ok      = (rx_ch != 4'h0) && (rx_ch <= `CH_MAX);
  wire        has_domain = rx_desc[`DESC_HAS_DOMAIN];
  wire        has_sync   = rx_desc[`DESC_HAS_SYNC];
  wire        has_dev    = rx_desc[`DESC_HAS_DEV];
  wire        domain_ok  = has_domain ? (rx_desc[23:16] == local_cfg[15:8])
                                      : ctrl[`CTRL_ALLOW_UNK];
  wire        use_sync   = has_domain && has_sync;
  wire        sync_ok    = !has_domain || has_sync || ctrl[`CTRL_ALLOW_GUESS];
  wire [15:0] dev_num    = has_dev ? rx_dev[31:16] : 16'h0001;
  wire [15:0] dev_den    = has_dev ? rx_dev[15:0]  : 16'h0001;
  wire [35:0] rate_lhs   = {16'h0000, rx_rate} * {20'h00000, dev_num};
  wire [35:0] rate_rhs   = {16'h0000, local_rate} * {20'h00000, dev_den};
  wire        rate_ok    = (dev_den != 16'h0000) && (rate_lhs == rate_rhs);
  wire        desc_ok    = addr_ok && ports_ok && fmt_ok && ch_ok && domain_ok
                           && sync_ok && rate_ok;

  // Unsigned 32-bit arithmetic keeps the epoch association valid across wraps
  wire [31:0] next_map_off = use_sync ? mclk_epoch - rx_sync + latency : latency;

  // ----------------------------------------
  // Receive start and mapping lock
  // ----------------------------------------
  logic        rx_en_q;
  logic        rx_run;
  logic [31:0] map_off;
  logic [3:0]  run_ch;

  wire rx_en   = ctrl[`CTRL_RX_EN];
  wire rx_rise = rx_en && !rx_en_q;

  // Mapping is taken once at start; a running stream is never realigned
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_en_q <= 1'b0;
      rx_run  <= 1'b0;
      map_off <= 32'h0000_0000;
      run_ch  <= 4'h1;
    end else begin
      rx_en_q <= rx_en;
      if (!rx_en) begin
        rx_run <= 1'b0;
      end else if (rx_rise) begin
        rx_run  <= desc_ok;
        map_off <= next_map_off;
        run_ch  <= ch_ok ? rx_ch : 4'h1;
      end
    end
  end

  assign rx_running_out = rx_run;
  assign status = {23'h000000, rx_run, rate_ok, sync_ok, domain_ok, ch_ok,
                   fmt_ok, ports_ok, addr_ok, desc_ok};

  // ----------------------------------------
  // Receive depacketizer and buffer
  // ----------------------------------------
  logic [31:0] rx_buf [0:`BUF_WORDS-1];
  logic [31:0] ts_base;
  logic [15:0] rx_frm;
  logic [3:0]  rx_chn;
  logic        in_pkt;

  assign rx_pkt_ready_out = 1'b1;

  wire        rx_hdr    = rx_pkt_valid_in && rx_pkt_in.first;
  wire        rx_smp    = rx_pkt_valid_in && !rx_pkt_in.first && in_pkt;
  wire        rx_fend   = (rx_chn == run_ch - 4'h1);
  wire [31:0] rx_pos32  = ts_base + {16'h0000, rx_frm};
  wire [12:0] rx_wr_idx = {rx_chn[`CH_IW-1:0], rx_pos32[`BUF_AW-1:0]};

  // Sample count per packet is never assumed; the packet ends at its last word
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ts_base <= 32'h0000_0000;
      rx_frm  <= 16'h0000;
      rx_chn  <= 4'h0;
      in_pkt  <= 1'b0;
      rx_pkts <= 32'h0000_0000;
    end else if (rx_hdr) begin
      ts_base <= rx_pkt_in.data + map_off;
      rx_frm  <= 16'h0000;
      rx_chn  <= 4'h0;
      in_pkt  <= rx_run && !rx_pkt_in.last;
      if (rx_run) begin
        rx_pkts <= rx_pkts + 32'h0000_0001;
      end
    end else if (rx_smp) begin
      rx_chn <= rx_fend ? 4'h0 : rx_chn + 4'h1;
      rx_frm <= rx_fend ? rx_frm + 16'h0001 : rx_frm;
      in_pkt <= !rx_pkt_in.last;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rx_smp && rx_run) begin
      rx_buf[rx_wr_idx] <= rx_pkt_in.data;
    end
  end

  // ----------------------------------------
  // Playout on the local media clock
  // ----------------------------------------
  logic                  play_act;
  logic [3:0]            play_chn;
  logic [`BUF_AW-1:0]    play_pos;

  wire        play_start = media_tick_in && rx_run && !play_act;
  wire [12:0] rd_idx     = {play_chn[`CH_IW-1:0], play_pos};

  // One channel per cycle; eight channels finish long before the next tick
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      play_act <= 1'b0;
      play_chn <= 4'h0;
      play_pos <= '0;
    end else if (play_start) begin
      play_act <= 1'b1;
      play_chn <= 4'h0;
      play_pos <= mclk[`BUF_AW-1:0];
    end else if (play_act) begin
      play_act <= (play_chn != run_ch - 4'h1);
      play_chn <= play_chn + 4'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      play_valid_out <= 1'b0;
      play_smp_out   <= '0;
    end else begin
      play_valid_out <= play_act;
      if (play_act) begin
        play_smp_out <= '{data: rx_buf[rd_idx], chan: play_chn[`CH_IW-1:0]};
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_TS_STAMP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tx_start |=> tx_pkt_valid_out && tx_pkt_out.first
                 && tx_pkt_out.data == $past(mclk) + $past(tx_offset))
    else $error("header timestamp is not media count plus offset");

  AST_MCLK_STEP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    media_tick_in && !mclk_wr |=> mclk == $past(mclk) + 32'h0000_0001)
    else $error("media count did not advance by one");

  AST_MCLK_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !media_tick_in && !mclk_wr |=> $stable(mclk))
    else $error("media count moved without a tick");

  AST_MTU: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tx_take && frame_end |-> pkt_bytes + frame_bytes <= pay_max)
    else $error("packet payload exceeds the network limit");

  AST_SEND_ASAP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tx_take |=> tx_pkt_valid_out && !tx_pkt_out.first)
    else $error("accepted sample not presented at once");

  AST_PKT_END: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tx_take && frame_end && spp_done |=> tx_pkt_out.last && !tx_smp_ready_out)
    else $error("packet did not end at the configured sample count");

  AST_REFUSE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_rise && !addr_ok |=> !rx_run [*2])
    else $error("stream with wrong address was accepted");

  AST_RATE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_rise && !rate_ok |=> !rx_run)
    else $error("stream with wrong rate was accepted");

  AST_LOCKED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_run && $past(rx_run) |-> $stable(map_off))
    else $error("stream mapping changed while running");

  AST_PLAY: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    play_start |=> play_act ##1 play_valid_out && play_smp_out.chan == 3'h0)
    else $error("playout did not follow the media tick");

endmodule

`default_nettype wire

// >>> design/media_stream_packetizer_params.svh
// Purpose: Register map, field positions and sizes of the media stream packetizer
// Assumes: Included by the design file and the testbench
// Notes:   Definitions only
`ifndef MEDIA_STREAM_PACKETIZER_PARAMS_SVH
`define MEDIA_STREAM_PACKETIZER_PARAMS_SVH

`define MSP_AW          8
`define MSP_DW          32
`define CH_MAX          4'h8
`define CH_IW           3
`define BUF_AW          10
`define BUF_DEPTH       1024
`define BUF_WORDS       8192
`define MTU_BYTES       17'h005DC
`define HDR_BYTES       17'h00028
`define MCAST_PREFIX    4'hE
`define L16_BYTES       3'h2
`define L24_BYTES       3'h3
`define W32_BYTES       3'h4

// Register offsets, byte addresses
`define REG_CTRL        8'h00
`define REG_TX_CFG      8'h04
`define REG_TX_OFFSET   8'h08
`define REG_MCLK        8'h0C
`define REG_LOCAL_ADDR  8'h10
`define REG_LOCAL_PORTS 8'h14
`define REG_LOCAL_CFG   8'h18
`define REG_LOCAL_RATE  8'h1C
`define REG_MCLK_EPOCH  8'h20
`define REG_LATENCY     8'h24
`define REG_RX_ADDR     8'h28
`define REG_RX_PORTS    8'h2C
`define REG_RX_DESC     8'h30
`define REG_RX_SYNC     8'h34
`define REG_RX_DEV      8'h38
`define REG_RX_RATE     8'h3C
`define REG_STATUS      8'h40
`define REG_TX_PKTS     8'h44
`define REG_TX_OCTETS   8'h48
`define REG_RX_PKTS     8'h4C

// Field positions
`define CTRL_TX_EN      0
`define CTRL_RX_EN      1
`define CTRL_UCAST_EN   2
`define CTRL_ALLOW_UNK  3
`define CTRL_ALLOW_GUESS 4
`define DESC_HAS_DOMAIN 6
`define DESC_HAS_SYNC   7
`define DESC_HAS_DEV    8

// Reset values
`define TX_CFG_RST      32'h0001_0030
`define LOCAL_RATE_RST  32'h0000_BB80

`endif

// >>> design/msp_pkg.sv
// Purpose: Types shared by the media stream packetizer
// Assumes: Constants live in media_stream_packetizer_params.svh
// Notes:   No imports; users write msp_pkg::name
package msp_pkg;

  typedef enum logic [1:0] {FMT_L16, FMT_L24, FMT_W32, FMT_BAD} fmt_t;

  typedef enum logic {TX_IDLE, TX_DATA} tx_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  chan;
  } sample_t;

  typedef struct packed {
    logic [31:0] data;
    logic        first;
    logic        last;
  } pkt_word_t;

endpackage

// >>> dv/net_node_model.sv
// Purpose: Far network node: takes transmit words, sends receive packets
// Assumes: Shares the packetizer clock
// Notes:   Sink ready toggles every cycle so transmit always meets stalls
`timescale 1ns/10ps
`default_nettype none
module net_node_model (
  // Clock
  input  wire logic               core_clk_in,
  // Transmit words from the packetizer
  input  wire msp_pkg::pkt_word_t tx_pkt_in,
  input  wire logic               tx_pkt_valid_in,
  output logic                    tx_pkt_ready_out,
  // Receive words to the packetizer
  output msp_pkg::pkt_word_t      rx_pkt_out,
  output logic                    rx_pkt_valid_out
);
  msp_pkg::pkt_word_t tx_q[$];
  initial begin
    tx_pkt_ready_out = 1'b0;
    rx_pkt_out       = '0;
    rx_pkt_valid_out = 1'b0;
  end
  always @(posedge core_clk_in) begin
    tx_pkt_ready_out <= ~tx_pkt_ready_out;
    if (tx_pkt_valid_in && tx_pkt_ready_out) tx_q.push_back(tx_pkt_in);
  end
  // Released bus shows the inverse of the last word, never a stale copy
  task automatic send_pkt(input logic [31:0] w[$]);
    foreach (w[i]) begin
      @(posedge core_clk_in);
      rx_pkt_out       <= {w[i], i == 0, i == w.size() - 1};
      rx_pkt_valid_out <= 1'b1;
    end
    @(posedge core_clk_in);
    rx_pkt_out       <= ~rx_pkt_out;
    rx_pkt_valid_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_media_stream_packetizer.sv
// Purpose: Self-checking bench for the media stream packetizer
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Media clock held still except where ticks are given
`include "media_stream_packetizer_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_media_stream_packetizer;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tick_s = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, sdata = 32'h1122_3344, ks = 32'h0;
  logic [15:0] sleft = 16'h0;
  logic svalid = 1'b0, sready, pvalid, pready, rvalid, rready, play_v, running;
  msp_pkg::pkt_word_t pkt, rpkt;
  msp_pkg::sample_t play;
  msp_pkg::sample_t play_q[$];
  int err_total = 0, check_count = 0, cycles = 0;
  always #5 clk = ~clk;
  media_stream_packetizer i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .media_tick_in(tick_s), .tx_smp_data_in(sdata), .tx_smp_valid_in(svalid),
    .tx_smp_ready_out(sready), .tx_pkt_out(pkt), .tx_pkt_valid_out(pvalid),
    .tx_pkt_ready_in(pready), .rx_pkt_in(rpkt), .rx_pkt_valid_in(rvalid),
    .rx_pkt_ready_out(rready), .play_smp_out(play), .play_valid_out(play_v),
    .rx_running_out(running));
  net_node_model i_node (.core_clk_in(clk), .tx_pkt_in(pkt), .tx_pkt_valid_in(pvalid),
    .tx_pkt_ready_out(pready), .rx_pkt_out(rpkt), .rx_pkt_valid_out(rvalid));
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [63:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk("register", rdata, exp);
  endtask
  task automatic tick;
    @(posedge clk);
    tick_s <= 1'b1;
    @(posedge clk);
    tick_s <= 1'b0;
  endtask
  // One packet of n samples; header stamp is the held media count plus offset
  task automatic txp(input logic [31:0] cfg, input int n);
    logic [31:0] d;
    int b;
    b = i_node.tx_q.size();
    wrr(`REG_TX_CFG, cfg);
    wrr(`REG_CTRL, 32'h1);
    sleft  <= n[15:0];
    svalid <= 1'b1;
    for (int t = 0; t < 2000 && i_node.tx_q.size() <= b + n; t++) @(posedge clk);
    wrr(`REG_CTRL, 32'h0);
    chk("header", i_node.tx_q[b], {32'h0000_1010, 2'b10});
    for (int i = 1; i <= n; i++) begin
      d = 32'h1122_3344 + ks * 32'h0101_0100;
      ks++;
      d = cfg[21:20] == 2'h0 ? {16'h0, d[31:16]} : cfg[21:20] == 2'h1 ? {8'h0, d[31:8]} : d;
      chk("sample", i_node.tx_q[b + i], {d, 1'b0, i == n});
    end
  endtask
  task automatic rx_try(input logic [31:0] desc, dev, rate, ctl, input logic exp);
    wrr(`REG_RX_DESC, desc);
    wrr(`REG_RX_DEV, dev);
    wrr(`REG_LOCAL_RATE, rate);
    wrr(`REG_CTRL, ctl);
    wrr(`REG_CTRL, ctl | 32'h2);
    @(posedge clk);
    #1 chk("running", running, exp);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
    if (svalid && sready) begin
      sdata <= sdata + 32'h0101_0100;
      sleft <= sleft - 16'h1;
      if (sleft == 16'h1) svalid <= 1'b0;
    end
    if (play_v === 1'b1) play_q.push_back(play);
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`REG_TX_CFG, `TX_CFG_RST);
    rdchk(`REG_LOCAL_RATE, `LOCAL_RATE_RST);
    wrr(`REG_STATUS, 32'hFFFF_FFFF);
    rdchk(`REG_STATUS, 32'h4C);
    rdchk(8'h80, 32'h0);
    chk("rx ready", rready, 1'b1);
    wrr(`REG_MCLK, 32'hFFFF_FFFE);
    repeat (3) tick();
    rdchk(`REG_MCLK, 32'h1);
    wrr(`REG_MCLK, 32'h10);
    wrr(`REG_TX_OFFSET, 32'h1000);
    txp(32'h0001_0001, 1);
    txp(32'h0011_0001, 1);
    txp(32'h0021_0001, 1);
    txp(32'h0012_0002, 4);
    txp(32'h0021_0190, 365);
    rdchk(`REG_TX_PKTS, 32'h5);
    rdchk(`REG_TX_OCTETS, 32'h5C9);
    wrr(`REG_LOCAL_ADDR, 32'h0A00_0001);
    wrr(`REG_RX_ADDR, 32'h0A00_0001);
    wrr(`REG_LOCAL_PORTS, 32'h1388_1389);
    wrr(`REG_RX_PORTS, 32'h1388_1389);
    wrr(`REG_RX_RATE, 32'hBB80);
    wrr(`REG_RX_SYNC, 32'h20);
    wrr(`REG_MCLK_EPOCH, 32'h30);
    wrr(`REG_LATENCY, 32'h4);
    rx_try(32'h0C8, 32'h0, 32'hBB80, 32'h0, 1'b0);
    rx_try(32'h0C8, 32'h0, 32'hBB80, 32'h4, 1'b1);
    wrr(`REG_LOCAL_ADDR, 32'hE000_0001);
    wrr(`REG_RX_ADDR, 32'hE000_0001);
    rx_try(32'h1C8, 32'h03E9_03E8, 32'hBB80, 32'h0, 1'b0);
    rx_try(32'h1C8, 32'h03E9_03E8, 32'hBBB0, 32'h0, 1'b1);
    rx_try(32'h088, 32'h0, 32'hBB80, 32'h0, 1'b0);
    rx_try(32'h088, 32'h0, 32'hBB80, 32'h8, 1'b1);
    rx_try(32'h088, 32'h0, 32'hBB80, 32'h10, 1'b0);
    rx_try(32'h048, 32'h0, 32'hBB80, 32'h0, 1'b0);
    rx_try(32'h048, 32'h0, 32'hBB80, 32'h10, 1'b1);
    rx_try(32'h0C9, 32'h0, 32'hBB80, 32'h0, 1'b0);
    rx_try(32'h0C8, 32'h0, 32'hBB80, 32'h0, 1'b1);
    rdchk(`REG_STATUS, 32'h1FF);
    i_node.send_pkt('{32'h100, 32'hA0, 32'hB0, 32'hA1, 32'hB1});
    wrr(`REG_MCLK, 32'h115);
    tick();
    repeat (6) @(posedge clk);
    chk("plays", play_q.size(), 2);
    chk("play0", play_q[0], {32'hA1, 3'h0});
    chk("play1", play_q[1], {32'hB1, 3'h1});
    rdchk(`REG_RX_PKTS, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
